// File: hdl/smcd_decoder.v
// safe control word decoder: apb registers, layout mapping, target outputs
//
// Our own choices: the APB register port and the register offsets.
`include "smcd_defs.vh"
`default_nettype none

module smcd_decoder
(
    // apb slave
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // safety function mode
    input wire [1:0] safety_mode,
    // received control word from the consumer connection
    input wire [15:0] rx_word,
    input wire rx_valid,
    // decoded targets
    output reg [18:0] control_target,
    output reg holding_brake_release,
    output reg home_reference,
    output reg local_safe_output,
    output reg connection_active,
    output wire [15:0] producer_type
);

    ////////////////////////////////////////////////////////////////////////////
    // register state
    reg bus_enable;
    reg fixed_profile;
    reg [15:0] cons_type;
    reg [15:0] prod_type;
    reg [15:0] mask_reg;
    reg [15:0] word_held;
    reg mask_error;

    wire apb_write;
    wire apb_read;
    wire addr_hit;
    wire cfg_mode;
    wire conn_mode;

    // zero wait state slave; every access finishes in its access cycle
    assign pready = 1'b1;
    assign apb_write = psel & penable & pwrite;
    assign apb_read = psel & penable & ~pwrite;
    assign cfg_mode = (safety_mode == `SMCD_MODE_CONFIG);
    assign conn_mode = (safety_mode == `SMCD_MODE_PARAM) | (safety_mode == `SMCD_MODE_OPER);
    assign producer_type = prod_type;

    // address decode
    assign addr_hit = (paddr == `SMCD_ADDR_CTRL) | (paddr == `SMCD_ADDR_CONS_TYPE) |
                      (paddr == `SMCD_ADDR_PROD_TYPE) | (paddr == `SMCD_ADDR_MASK) |
                      (paddr == `SMCD_ADDR_STATUS) | (paddr == `SMCD_ADDR_RX_WORD) |
                      (paddr == `SMCD_ADDR_TARGET) | (paddr == `SMCD_ADDR_OUTPUTS);
    assign pslverr = psel & penable & ~addr_hit;

    ////////////////////////////////////////////////////////////////////////////
    // layout recognition
    reg type_ok;
    reg is_coded;
    reg [15:0] code_field;
    reg [15:0] reserved_bits;

    // only the six predefined layouts are known; anything else is refused
    always @*
    begin
        type_ok = 1'b1;
        is_coded = 1'b0;
        code_field = 16'h0000;
        reserved_bits = 16'h0000;
        case (cons_type)
            `SMCD_TYPE_778:
            begin
                reserved_bits = `SMCD_RSV_BYTE; // single byte word
            end
            `SMCD_TYPE_779:
            begin
                is_coded = 1'b1;
                code_field = `SMCD_CODE3_FIELD;
                reserved_bits = `SMCD_RSV_BYTE;
            end
            `SMCD_TYPE_780:
            begin
                reserved_bits = 16'h0000;
            end
            `SMCD_TYPE_781:
            begin
                is_coded = 1'b1;
                code_field = `SMCD_CODE4_FIELD;
                reserved_bits = `SMCD_RSV_781;
            end
            `SMCD_TYPE_786:
            begin
                reserved_bits = `SMCD_RSV_786;
            end
            `SMCD_TYPE_787:
            begin
                is_coded = 1'b1;
                code_field = `SMCD_CODE4_FIELD;
                reserved_bits = `SMCD_RSV_787;
            end
            default:
            begin
                type_ok = 1'b0;
                reserved_bits = `SMCD_RSV_ALL;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // effective mask: a partly masked coded field is masked whole
    wire [15:0] mask_eff;
    wire code_part_masked;

    assign code_part_masked = |(mask_reg & code_field);
    assign mask_eff = code_part_masked ? (mask_reg | code_field) : mask_reg;

    wire [15:0] word_conn;

    smcd_bit_connector u_conn
    (
        .word_in(word_held),
        .mask(mask_eff),
        .reserved(reserved_bits),
        .word_out(word_conn)
    );

    ////////////////////////////////////////////////////////////////////////////
    // coded selection decode
    wire [3:0] code_in;
    wire [15:0] code_sel;

    // the 3-bit field gets a zero top bit, so 779 never reaches beyond seven
    assign code_in = (cons_type == `SMCD_TYPE_779) ? {1'b0, word_conn[5:3]} :
                     word_conn[6:3];

    smcd_onehot_dec u_dec
    (
        .code(code_in),
        .sel(code_sel)
    );

    ////////////////////////////////////////////////////////////////////////////
    // target mapping per layout
    reg [18:0] next_target;
    reg next_brake;
    reg next_home;
    reg next_lso;

    always @*
    begin
        next_target = 19'h00000;
        next_brake = 1'b0;
        next_home = 1'b0;
        next_lso = 1'b0;
        // common mode select, emergency stop, enable
        next_target[`SMCD_B_MODE_SEL] = word_conn[`SMCD_B_MODE_SEL];
        next_target[`SMCD_B_ESTOP] = word_conn[`SMCD_B_ESTOP];
        next_target[`SMCD_B_ENABLE] = word_conn[`SMCD_B_ENABLE];
        case (cons_type)
            `SMCD_TYPE_778:
            begin
                next_target[6:3] = word_conn[6:3];
                next_lso = word_conn[`SMCD_B_BYTE_LSO];
            end
            `SMCD_TYPE_779:
            begin
                next_target[10:3] = code_sel[7:0];
                next_brake = word_conn[`SMCD_B_779_BRAKE];
                next_lso = word_conn[`SMCD_B_BYTE_LSO];
            end
            `SMCD_TYPE_780:
            begin
                next_target[14:3] = word_conn[14:3];
                next_lso = word_conn[`SMCD_B_WORD_LSO];
            end
            `SMCD_TYPE_781:
            begin
                next_target[18:3] = code_sel;
                next_brake = word_conn[`SMCD_B_WORD_BRAKE];
                next_lso = word_conn[`SMCD_B_WORD_LSO];
            end
            `SMCD_TYPE_786:
            begin
                next_target[12:3] = word_conn[12:3];
                next_home = word_conn[`SMCD_B_786_HOME] & `SMCD_HOME_REF_SUPPORTED;
                next_lso = word_conn[`SMCD_B_WORD_LSO];
            end
            `SMCD_TYPE_787:
            begin
                next_target[18:3] = code_sel;
                next_brake = word_conn[`SMCD_B_WORD_BRAKE];
                next_home = word_conn[`SMCD_B_787_HOME] & `SMCD_HOME_REF_SUPPORTED;
                next_lso = word_conn[`SMCD_B_WORD_LSO];
            end
            default:
            begin
                next_target = 19'h00000;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // connection: only when switched on, in parameter or operating mode,
    // with a known layout; otherwise every target falls inactive
    wire next_active;

    assign next_active = bus_enable & conn_mode & type_ok;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            connection_active <= 1'b0;
            control_target <= 19'h00000;
            holding_brake_release <= 1'b0;
            home_reference <= 1'b0;
            local_safe_output <= 1'b0;
        end
        else
        begin
            connection_active <= next_active;
            if (next_active)
            begin
                control_target <= next_target;
                holding_brake_release <= next_brake;
                home_reference <= next_home;
                local_safe_output <= next_lso;
            end
            else
            begin
                control_target <= 19'h00000;
                holding_brake_release <= 1'b0;
                home_reference <= 1'b0;
                local_safe_output <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // received word capture; cleared when the connection drops so a stale
    // word cannot reappear on reconnection
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            word_held <= 16'h0000;
        end
        else if (!(bus_enable & conn_mode))
        begin
            word_held <= 16'h0000;
        end
        else if (rx_valid)
        begin
            word_held <= rx_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register writes; switching and layout changes only in configuration mode
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bus_enable <= 1'b0;
            fixed_profile <= 1'b0;
            cons_type <= `SMCD_RST_TYPE;
            prod_type <= `SMCD_RST_PROD;
            mask_reg <= `SMCD_RST_MASK;
        end
        else if (apb_write)
        begin
            if ((paddr == `SMCD_ADDR_CTRL) && cfg_mode)
            begin
                bus_enable <= pwdata[`SMCD_CTRL_BUS_EN];
                fixed_profile <= pwdata[`SMCD_CTRL_FIXED];
            end
            else if ((paddr == `SMCD_ADDR_CONS_TYPE) && cfg_mode)
            begin
                cons_type <= pwdata[15:0];
                if (fixed_profile)
                begin
                    prod_type <= pwdata[15:0] + `SMCD_PROFILE_OFFSET;
                end
            end
            else if ((paddr == `SMCD_ADDR_PROD_TYPE) && cfg_mode && !fixed_profile)
            begin
                prod_type <= pwdata[15:0];
            end
            else if (paddr == `SMCD_ADDR_MASK)
            begin
                mask_reg <= pwdata[15:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky mask error: set wins over the clear by a write of one
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mask_error <= 1'b0;
        end
        else if (code_part_masked && (mask_reg & code_field) != code_field)
        begin
            mask_error <= 1'b1;
        end
        else if (apb_write && (paddr == `SMCD_ADDR_STATUS) && pwdata[`SMCD_ST_MASK_ERR])
        begin
            mask_error <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux
    always @*
    begin
        prdata = 32'h00000000;
        if (apb_read)
        begin
            if (paddr == `SMCD_ADDR_CTRL)
            begin
                prdata[`SMCD_CTRL_BUS_EN] = bus_enable;
                prdata[`SMCD_CTRL_FIXED] = fixed_profile;
            end
            else if (paddr == `SMCD_ADDR_CONS_TYPE)
            begin
                prdata[15:0] = cons_type;
            end
            else if (paddr == `SMCD_ADDR_PROD_TYPE)
            begin
                prdata[15:0] = prod_type;
            end
            else if (paddr == `SMCD_ADDR_MASK)
            begin
                prdata[15:0] = mask_reg;
            end
            else if (paddr == `SMCD_ADDR_STATUS)
            begin
                prdata[`SMCD_ST_ACTIVE] = connection_active;
                prdata[`SMCD_ST_CFG_ERR] = ~type_ok;
                prdata[`SMCD_ST_MASK_ERR] = mask_error;
                prdata[`SMCD_ST_CFG_MODE] = cfg_mode;
            end
            else if (paddr == `SMCD_ADDR_RX_WORD)
            begin
                prdata[15:0] = word_held;
            end
            else if (paddr == `SMCD_ADDR_TARGET)
            begin
                prdata[18:0] = control_target;
            end
            else if (paddr == `SMCD_ADDR_OUTPUTS)
            begin
                prdata[`SMCD_OUT_BRAKE] = holding_brake_release;
                prdata[`SMCD_OUT_HOME] = home_reference;
                prdata[`SMCD_OUT_LSO] = local_safe_output;
            end
        end
    end

endmodule

`default_nettype wire

// File: hdl/smcd_defs.vh
// constants for the safe control word decoder: types, offsets, field positions
`ifndef SMCD_DEFS_VH
`define SMCD_DEFS_VH

// consumer layout type numbers
`define SMCD_TYPE_778 16'h030A
`define SMCD_TYPE_779 16'h030B
`define SMCD_TYPE_780 16'h030C
`define SMCD_TYPE_781 16'h030D
`define SMCD_TYPE_786 16'h0312
`define SMCD_TYPE_787 16'h0313
// producer type paired with a consumer type under the fixed profile
`define SMCD_PROFILE_OFFSET 16'h0004

// apb byte addresses
`define SMCD_ADDR_CTRL 12'h000
`define SMCD_ADDR_CONS_TYPE 12'h004
`define SMCD_ADDR_PROD_TYPE 12'h008
`define SMCD_ADDR_MASK 12'h00C
`define SMCD_ADDR_STATUS 12'h010
`define SMCD_ADDR_RX_WORD 12'h014
`define SMCD_ADDR_TARGET 12'h018
`define SMCD_ADDR_OUTPUTS 12'h01C

// control register fields
`define SMCD_CTRL_BUS_EN 0
`define SMCD_CTRL_FIXED 1

// status register fields
`define SMCD_ST_ACTIVE 0
`define SMCD_ST_CFG_ERR 1
`define SMCD_ST_MASK_ERR 2
`define SMCD_ST_CFG_MODE 3

// outputs register fields
`define SMCD_OUT_BRAKE 0
`define SMCD_OUT_HOME 1
`define SMCD_OUT_LSO 2

// safety function modes on the mode input
`define SMCD_MODE_CONFIG 2'h0
`define SMCD_MODE_PARAM 2'h1
`define SMCD_MODE_OPER 2'h2

// reset values
`define SMCD_RST_TYPE 16'h030A
`define SMCD_RST_PROD 16'h030E
`define SMCD_RST_MASK 16'h0000

// control word field positions
`define SMCD_B_MODE_SEL 0
`define SMCD_B_ESTOP 1
`define SMCD_B_ENABLE 2
`define SMCD_B_SEL_LO 3
`define SMCD_B_779_BRAKE 6
`define SMCD_B_BYTE_LSO 7
`define SMCD_B_787_HOME 7
`define SMCD_B_786_HOME 13
`define SMCD_B_WORD_BRAKE 14
`define SMCD_B_WORD_LSO 15

// coded field masks over the control word
`define SMCD_CODE3_FIELD 16'h0038
`define SMCD_CODE4_FIELD 16'h0078

// reserved bits per layout; an unknown layout has every bit reserved
`define SMCD_RSV_BYTE 16'hFF00
`define SMCD_RSV_781 16'h3F80
`define SMCD_RSV_786 16'h4000
`define SMCD_RSV_787 16'h3F00
`define SMCD_RSV_ALL 16'hFFFF

// home reference available in this firmware release
`define SMCD_HOME_REF_SUPPORTED 1'b1

`endif

// File: hdl/smcd_onehot_dec.v
// binary code to one-hot selection decoder; code zero selects nothing
`default_nettype none

module smcd_onehot_dec
(
    // code in
    input wire [3:0] code,
    // one-hot out, bit n-1 for code n
    output wire [15:0] sel
);

    ////////////////////////////////////////////////////////////////////////////
    // one comparator per selection; code 0 matches none of them
    genvar i;
    generate
        for (i = 0; i < 16; i = i + 1)
        begin : g_sel
            // one bit wider than the code so that selection sixteen cannot wrap onto code 0
            localparam [4:0] SEL_CODE = i + 1;
            assign sel[i] = ({1'b0, code} == SEL_CODE);
        end
    endgenerate

endmodule

`default_nettype wire

// File: hdl/smcd_bit_connector.v
// per-bit connector: passes control word bits that are neither masked nor reserved by the layout
`default_nettype none

module smcd_bit_connector
(
    // raw control word
    input wire [15:0] word_in,
    // effective mask, one means the target is freed
    input wire [15:0] mask,
    // reserved bits of the selected layout
    input wire [15:0] reserved,
    // connected word
    output wire [15:0] word_out
);

    ////////////////////////////////////////////////////////////////////////////
    // masked and reserved bits never reach a target
    genvar i;
    generate
        for (i = 0; i < 16; i = i + 1)
        begin : g_bit
            assign word_out[i] = word_in[i] & ~mask[i] & ~reserved[i];
        end
    endgenerate

endmodule

`default_nettype wire

// File: bench/smcd_ctrl_model.sv
// behavioural safety controller that sends control words on the consumer connection
`default_nettype none

module smcd_ctrl_model
(
    // clock and request from the bench
    input wire logic pclk,
    input wire logic send_req,
    input wire logic [15:0] word,
    // consumer connection toward the drive
    output var logic [15:0] rx_word,
    output var logic rx_valid
);

////////////////////////////////////////////////////////////////////////////////
// idle value at time zero
initial
begin
    rx_word = 16'h0000;
    rx_valid = 1'b0;
end

// only whole predefined words go out; between words the data toggles, so a
// decoder that samples without the valid pulse sees garbage, not the last word
always @(posedge pclk)
begin
    rx_valid <= send_req;
    rx_word <= send_req ? word : ~rx_word;
end

endmodule

`default_nettype wire

// File: bench/smcd_decoder_asserts.sv
// port-level assertion checker for the safe control word decoder
`default_nettype none

module smcd_decoder_asserts
(
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // link and targets
    input wire logic [1:0] safety_mode,
    input wire logic [15:0] rx_word,
    input wire logic rx_valid,
    input wire logic [18:0] control_target,
    input wire logic holding_brake_release,
    input wire logic home_reference,
    input wire logic local_safe_output,
    input wire logic connection_active,
    input wire logic [15:0] producer_type
);

default clocking cb @(posedge pclk);
endclocking
default disable iff (!presetn);

////////////////////////////////////////////////////////////////////////////////
// access phase and mapped address decode
wire logic acc = psel && penable;
wire logic mapped = (paddr[1:0] == 2'h0) && (paddr <= 12'h01C);
wire logic wr_acc = acc && pwrite;

// bus answers
property p_ready;
    acc |-> pready;
endproperty
a_ready: assert property (p_ready) else $error("access phase without ready");
property p_err_unmapped;
    acc && !mapped |-> pslverr && prdata == 32'h0;
endproperty
a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");
property p_err_mapped;
    !(acc && !mapped) |-> !pslverr;
endproperty
a_err_mapped: assert property (p_err_mapped) else $error("error response out of place");
property p_rdata_idle;
    !(acc && !pwrite) |-> prdata == 32'h0;
endproperty
a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read access");

// connection follows the safety mode
property p_cfg_drop;
    safety_mode == 2'h0 || safety_mode == 2'h3 |=> !connection_active;
endproperty
a_cfg_drop: assert property (p_cfg_drop) else $error("connection kept outside run modes");
property p_rise;
    $rose(connection_active) |-> $past(safety_mode) inside {2'h1, 2'h2};
endproperty
a_rise: assert property (p_rise) else $error("connection opened in wrong mode");
property p_off_zero;
    !connection_active && !$past(connection_active) |-> control_target == 19'h0
        && !holding_brake_release && !home_reference && !local_safe_output;
endproperty
a_off_zero: assert property (p_off_zero) else $error("target active without connection");
property p_prod;
    $changed(producer_type) |-> $past(wr_acc) && $past(safety_mode) == 2'h0;
endproperty
a_prod: assert property (p_prod) else $error("producer type moved without config write");
property p_change;
    $changed(control_target) && connection_active && $past(connection_active)
        |-> $past(rx_valid, 2) || $past(wr_acc, 1) || $past(wr_acc, 2);
endproperty
a_change: assert property (p_change) else $error("targets changed without a new word");

endmodule

bind smcd_decoder smcd_decoder_asserts u_chk
(
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .safety_mode, .rx_word, .rx_valid, .control_target,
    .holding_brake_release, .home_reference, .local_safe_output,
    .connection_active, .producer_type
);

`default_nettype wire

// File: bench/smcd_decoder_tb.sv
// self-checking testbench for the safe control word decoder
`default_nettype none
`include "smcd_defs.vh"

module smcd_decoder_tb;
timeunit 1ns;
timeprecision 1ps;

logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_valid, send_req, rd_err;
logic [11:0] paddr;
logic [31:0] pwdata, prdata, rd_val;
logic [1:0] safety_mode;
logic [15:0] rx_word, word, producer_type;
logic [18:0] control_target;
logic holding_brake_release, home_reference, local_safe_output, connection_active;
integer seed = 32'h9054;
integer miscompares = 0;
integer tests_run = 0;
logic [15:0] types [6] = '{`SMCD_TYPE_778, `SMCD_TYPE_779, `SMCD_TYPE_780,
    `SMCD_TYPE_781, `SMCD_TYPE_786, `SMCD_TYPE_787};

////////////////////////////////////////////////////////////////////////////////
// clock, design and controller model
initial
begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
end

smcd_decoder dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .safety_mode, .rx_word, .rx_valid, .control_target,
    .holding_brake_release, .home_reference, .local_safe_output, .connection_active,
    .producer_type);
smcd_ctrl_model u_ctrl (.pclk, .send_req, .word, .rx_word, .rx_valid);

////////////////////////////////////////////////////////////////////////////////
// expectation helpers
function logic known(input logic [15:0] t);
    return t inside {`SMCD_TYPE_778, `SMCD_TYPE_779, `SMCD_TYPE_780,
        `SMCD_TYPE_781, `SMCD_TYPE_786, `SMCD_TYPE_787};
endfunction

// returns {safe output, home, brake, targets}; coded fields go one-hot
function logic [21:0] f_exp(input logic [15:0] t, input logic [15:0] w);
    logic [18:0] g;
    logic b, h, o;
    g = {16'h0000, w[2:0]};
    case (t)
        `SMCD_TYPE_778: g[6:3] = w[6:3];
        `SMCD_TYPE_779: g[10:3] = (8'h01 << w[5:3]) >> 1;
        `SMCD_TYPE_780: g[14:3] = w[14:3];
        `SMCD_TYPE_786: g[12:3] = w[12:3];
        default: g[18:3] = (16'h0001 << w[6:3]) >> 1;
    endcase
    b = (t == `SMCD_TYPE_779) ? w[6] : (t == `SMCD_TYPE_781 || t == `SMCD_TYPE_787) & w[14];
    h = (t == `SMCD_TYPE_786) ? w[13] : (t == `SMCD_TYPE_787) & w[7];
    o = (t == `SMCD_TYPE_778 || t == `SMCD_TYPE_779) ? w[7] : w[15];
    return known(t) ? {o, h, b, g} : 22'h0;
endfunction

////////////////////////////////////////////////////////////////////////////////
// compare, bus and link tasks
task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp)
    begin
        miscompares = miscompares + 1;
        $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
endtask

// one apb transfer; the idle cycle after it keeps psel from being set twice at one edge
task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no wait count is assumed; a slave that never answers is left to the watchdog
    while (pready !== 1'b1)
        @(posedge pclk);
    rd_val = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
endtask

task rd_chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd_val, e);
endtask

// configure a layout in config mode, then enter a random run mode
task cfg(input logic [15:0] t);
    safety_mode <= `SMCD_MODE_CONFIG;
    @(posedge pclk);
    apb(1'b1, `SMCD_ADDR_CTRL, 32'h1);
    apb(1'b1, `SMCD_ADDR_MASK, 32'h0);
    apb(1'b1, `SMCD_ADDR_CONS_TYPE, {16'h0000, t});
    safety_mode <= ($random(seed) & 1) ? `SMCD_MODE_OPER : `SMCD_MODE_PARAM;
    @(posedge pclk);
endtask

// send one word under mask m and compare ports and registers
task send(input logic [15:0] t, input logic [15:0] w, input logic [15:0] m);
    logic [21:0] e;
    e = f_exp(t, w & ~m);
    send_req <= 1'b1;
    word <= w;
    @(posedge pclk);
    send_req <= 1'b0;
    repeat (4) @(posedge pclk);
    chk({10'h0, local_safe_output, home_reference, holding_brake_release, control_target},
        {10'h0, e});
    chk({31'h0, connection_active}, {31'h0, known(t)});
    rd_chk(`SMCD_ADDR_TARGET, {13'h0, e[18:0]});
    rd_chk(`SMCD_ADDR_OUTPUTS, {29'h0, e[21:19]});
endtask

task final_report;
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
        $display("== PASSED ==");
    else
        $display("== FAILED ==");
    $finish;
endtask

////////////////////////////////////////////////////////////////////////////////
// main sequence
initial
begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    safety_mode = `SMCD_MODE_CONFIG;
    send_req = 1'b0;
    word = 16'h0000;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({16'h0, producer_type}, {16'h0, `SMCD_RST_PROD});
    rd_chk(`SMCD_ADDR_CONS_TYPE, {16'h0, `SMCD_RST_TYPE});
    rd_chk(`SMCD_ADDR_MASK, 32'h0);
    rd_chk(`SMCD_ADDR_STATUS, 32'h8);
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, rd_err}, 32'h1);
    $display("test reset and map done");
    for (int k = 0; k < 6; k++)
    begin
        cfg(types[k]);
        send(types[k], 16'hFFFF, 16'h0);
        send(types[k], 16'h0000, 16'h0);
        for (int i = 0; i < 16; i++)
            send(types[k], 16'(i << 3) | 16'h8007, 16'h0);
        repeat (6) send(types[k], 16'($random(seed)), 16'h0);
        $display("test layout %h done", types[k]);
    end
    apb(1'b1, `SMCD_ADDR_CONS_TYPE, {16'h0, `SMCD_TYPE_778});
    rd_chk(`SMCD_ADDR_CONS_TYPE, {16'h0, `SMCD_TYPE_787});
    apb(1'b1, `SMCD_ADDR_MASK, 32'h0010);
    send(`SMCD_TYPE_787, 16'hFFFF, 16'h0078);
    rd_chk(`SMCD_ADDR_STATUS, 32'h5);
    apb(1'b1, `SMCD_ADDR_MASK, 32'h8001);
    send(`SMCD_TYPE_787, 16'hFFFF, 16'h8001);
    safety_mode <= `SMCD_MODE_CONFIG;
    repeat (3) @(posedge pclk);
    chk({12'h0, connection_active, control_target}, 32'h0);
    $display("test mask and mode done");
    cfg(`SMCD_RST_PROD);
    send(`SMCD_RST_PROD, 16'hFFFF, 16'h0);
    rd_chk(`SMCD_ADDR_STATUS, 32'h6);
    apb(1'b1, `SMCD_ADDR_STATUS, 32'h4);
    rd_chk(`SMCD_ADDR_STATUS, 32'h2);
    safety_mode <= `SMCD_MODE_CONFIG;
    @(posedge pclk);
    apb(1'b1, `SMCD_ADDR_CTRL, 32'h3);
    apb(1'b1, `SMCD_ADDR_CONS_TYPE, {16'h0, `SMCD_TYPE_779});
    chk({16'h0, producer_type}, {16'h0, `SMCD_TYPE_779 + `SMCD_PROFILE_OFFSET});
    apb(1'b1, `SMCD_ADDR_PROD_TYPE, 32'h1234);
    chk({16'h0, producer_type}, {16'h0, `SMCD_TYPE_779 + `SMCD_PROFILE_OFFSET});
    $display("test unsupported and profile done");
    final_report;
end

// watchdog, far beyond the roughly 1750 cycles the sequence needs
initial
begin
    repeat (30000) @(posedge pclk);
    miscompares = miscompares + 1;
    final_report;
end

endmodule

`default_nettype wire
